/* File: design/aec_top.sv */
// adaptive equalizer control: register slice and error-checked adaptation machine
`timescale 1ns/1ps
module aec_top (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // internal register port from the device control interface
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // receiver status, same clock
    input wire logic [15:0] adapt_relock_period_i,
    input wire logic link_clock_err_i,
    input wire logic encoding_err_i,
    input wire logic parity_err_i,
    input wire logic lock_i,
    // settings towards the receiver
    output logic [3:0] eq_setting_o,
    output logic [3:0] sample_filter_o,
    output logic [15:0] fixed_test_pattern_lo_o,
    output logic adapt_locked_o
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [7:0] patt_lo;       // test pattern low byte
        logic [7:0] rsv_3b;        // reserved bytes, kept read/write
        logic [7:0] rsv_3c;
        logic [7:0] rsv_3d;
        logic [7:0] rsv_3e;
        logic [7:0] rsv_3f;
        logic [7:0] rsv_40;
        logic [7:0] sflt_cfg;      // upper and lower filter limits
        logic [6:0] adapt_ctl;     // bit 7 reads zero
        logic [7:0] thold;         // error threshold
        logic [7:0] rdata;         // registered read data
        aec_pkg::aec_state_t st;   // adaptation state
        logic [15:0] timer;        // window timer
        logic [15:0] err_cnt;      // accumulated errors
        logic [3:0] eq;            // equalizer setting
        logic [3:0] filt;          // sample filter setting
        logic locked;              // monitoring a good setting
    } aec_state_s_t;

    aec_state_s_t s_reg;
    aec_state_s_t s_next;

    // ****************************************************************
    // decoded controls
    // ****************************************************************
    logic [2:0] err_sel;
    logic two_step;
    logic loop_order;
    logic filt_en;
    logic [3:0] upper_lim;
    logic [3:0] lower_lim;
    logic sel_err;
    logic [15:0] full_per;
    logic [15:0] half_per;
    logic [15:0] wait_len;
    logic [3:0] step_eq;
    logic [3:0] step_filt;
    logic [3:0] filt_lo;
    logic [3:0] filt_hi;

    // control fields; bit 3 is stored for software but steers nothing here
    assign err_sel = s_reg.adapt_ctl[aec_pkg::ERR_SEL_HI:aec_pkg::ERR_SEL_LO];
    assign two_step = s_reg.adapt_ctl[aec_pkg::TWO_STEP_BIT];
    assign loop_order = s_reg.adapt_ctl[aec_pkg::LOOP_ORDER_BIT];
    assign filt_en = s_reg.adapt_ctl[aec_pkg::FILT_EN_BIT];
    assign upper_lim = s_reg.sflt_cfg[aec_pkg::UPPER_HI:aec_pkg::UPPER_LO];
    assign lower_lim = s_reg.sflt_cfg[aec_pkg::LOWER_HI:aec_pkg::LOWER_LO];
    // only errors whose class is selected count
    assign sel_err = |(err_sel & {link_clock_err_i, encoding_err_i, parity_err_i});
    // period comes from outside; a zero period is treated as one cycle
    assign full_per = (adapt_relock_period_i == 16'h0000) ? 16'h0001 : adapt_relock_period_i;
    assign half_per = (full_per[15:1] == 15'h0000) ? 16'h0001 : {1'b0, full_per[15:1]};
    assign wait_len = two_step ? half_per : full_per;
    // limits clipped to the legal range; upper below lower is software's fault
    assign filt_hi = (upper_lim > aec_pkg::FILT_MAX) ? aec_pkg::FILT_MAX : upper_lim;
    assign filt_lo = (lower_lim > filt_hi) ? filt_hi : lower_lim;

    // ****************************************************************
    // next setting of the nested search
    // ****************************************************************
    // the inner search advances each step and carries into the outer one
    always_comb begin
        step_eq = s_reg.eq;
        step_filt = s_reg.filt;
        if (!filt_en) begin
            // equalizer only; filter left where it is
            step_eq = s_reg.eq + 4'h1;
        end else if (!loop_order) begin
            // equalizer inner, filter outer
            step_eq = s_reg.eq + 4'h1;
            if (s_reg.eq == aec_pkg::EQ_MAX) begin
                step_filt = (s_reg.filt >= filt_hi) ? filt_lo : s_reg.filt + 4'h1;
            end
        end else begin
            // filter inner, equalizer outer
            step_filt = (s_reg.filt >= filt_hi) ? filt_lo : s_reg.filt + 4'h1;
            if (s_reg.filt >= filt_hi) begin
                step_eq = s_reg.eq + 4'h1;
            end
        end
    end

    // ****************************************************************
    // register writes, read mux and adaptation machine
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        // register writes
        if (reg_wr_i) begin
            if (reg_addr_i == aec_pkg::ADDR_PATT_LO) begin
                s_next.patt_lo = reg_wdata_i;
            end else if (reg_addr_i == aec_pkg::ADDR_RSV_3B) begin
                s_next.rsv_3b = reg_wdata_i;
            end else if (reg_addr_i == aec_pkg::ADDR_RSV_3C) begin
                s_next.rsv_3c = reg_wdata_i;
            end else if (reg_addr_i == aec_pkg::ADDR_RSV_3D) begin
                s_next.rsv_3d = reg_wdata_i;
            end else if (reg_addr_i == aec_pkg::ADDR_RSV_3E) begin
                s_next.rsv_3e = reg_wdata_i;
            end else if (reg_addr_i == aec_pkg::ADDR_RSV_3F) begin
                s_next.rsv_3f = reg_wdata_i;
            end else if (reg_addr_i == aec_pkg::ADDR_RSV_40) begin
                s_next.rsv_40 = reg_wdata_i;
            end else if (reg_addr_i == aec_pkg::ADDR_SFLT_CFG) begin
                s_next.sflt_cfg = reg_wdata_i;
            end else if (reg_addr_i == aec_pkg::ADDR_ADAPT_CTL) begin
                // bit 7 of the control byte is read-only, so it is dropped
                s_next.adapt_ctl = reg_wdata_i[6:0];
            end else if (reg_addr_i == aec_pkg::ADDR_ERR_THOLD) begin
                s_next.thold = reg_wdata_i;
            end
        end
        // read data follows the address one cycle later; unmapped reads zero
        if (reg_addr_i == aec_pkg::ADDR_PATT_LO) begin
            s_next.rdata = s_reg.patt_lo;
        end else if (reg_addr_i == aec_pkg::ADDR_RSV_3B) begin
            s_next.rdata = s_reg.rsv_3b;
        end else if (reg_addr_i == aec_pkg::ADDR_RSV_3C) begin
            s_next.rdata = s_reg.rsv_3c;
        end else if (reg_addr_i == aec_pkg::ADDR_RSV_3D) begin
            s_next.rdata = s_reg.rsv_3d;
        end else if (reg_addr_i == aec_pkg::ADDR_RSV_3E) begin
            s_next.rdata = s_reg.rsv_3e;
        end else if (reg_addr_i == aec_pkg::ADDR_RSV_3F) begin
            s_next.rdata = s_reg.rsv_3f;
        end else if (reg_addr_i == aec_pkg::ADDR_RSV_40) begin
            s_next.rdata = s_reg.rsv_40;
        end else if (reg_addr_i == aec_pkg::ADDR_SFLT_CFG) begin
            s_next.rdata = s_reg.sflt_cfg;
        end else if (reg_addr_i == aec_pkg::ADDR_ADAPT_CTL) begin
            s_next.rdata = {1'b0, s_reg.adapt_ctl};
        end else if (reg_addr_i == aec_pkg::ADDR_ERR_THOLD) begin
            s_next.rdata = s_reg.thold;
        end else begin
            s_next.rdata = 8'h00;
        end
        // adaptation machine
        s_next.timer = s_reg.timer + 16'h0001;
        case (s_reg.st)
            aec_pkg::ST_WAIT: begin
                s_next.locked = 1'b0;
                if (s_reg.timer >= wait_len - 16'h0001) begin
                    s_next.timer = 16'h0000;
                    s_next.err_cnt = 16'h0000;
                    if (two_step) begin
                        // first half done, now look for errors
                        s_next.st = aec_pkg::ST_ERRCHK;
                    end else if (lock_i) begin
                        // judged on the lock level at this instant
                        s_next.st = aec_pkg::ST_MONITOR;
                    end else begin
                        s_next.eq = step_eq;
                        s_next.filt = step_filt;
                    end
                end
            end
            aec_pkg::ST_ERRCHK: begin
                if (sel_err) begin
                    // any selected error rejects the setting at once
                    s_next.eq = step_eq;
                    s_next.filt = step_filt;
                    s_next.timer = 16'h0000;
                    s_next.st = aec_pkg::ST_WAIT;
                end else if (s_reg.timer >= half_per - 16'h0001) begin
                    s_next.timer = 16'h0000;
                    s_next.st = lock_i ? aec_pkg::ST_MONITOR : aec_pkg::ST_WAIT;
                    if (!lock_i) begin
                        s_next.eq = step_eq;
                        s_next.filt = step_filt;
                    end
                end
            end
            aec_pkg::ST_MONITOR: begin
                s_next.locked = 1'b1;
                // saturate rather than wrap so a storm never looks quiet
                if (sel_err && s_reg.err_cnt != 16'hFFFF) begin
                    s_next.err_cnt = s_reg.err_cnt + 16'h0001;
                end
                if (s_reg.timer >= half_per - 16'h0001) begin
                    s_next.timer = 16'h0000;
                    s_next.err_cnt = 16'h0000;
                    if (s_reg.err_cnt > {8'h00, s_reg.thold}) begin
                        s_next.eq = step_eq;
                        s_next.filt = step_filt;
                        s_next.locked = 1'b0;
                        s_next.st = aec_pkg::ST_WAIT;
                    end
                end
            end
            default: begin
                s_next.st = aec_pkg::ST_WAIT;
            end
        endcase
        // filter setting held inside the programmed limits from the edge after a limit write
        if (s_next.filt > filt_hi) begin
            s_next.filt = filt_hi;
        end else if (s_next.filt < filt_lo) begin
            s_next.filt = filt_lo;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_reg <= '{patt_lo: aec_pkg::RST_PATT_LO, rsv_3b: aec_pkg::RST_RSV_3B, rsv_3c: aec_pkg::RST_RSV_3C,
                       rsv_3d: aec_pkg::RST_RSV_3D, rsv_3e: aec_pkg::RST_RSV_3E, rsv_3f: aec_pkg::RST_RSV_3F,
                       rsv_40: aec_pkg::RST_RSV_40, sflt_cfg: aec_pkg::RST_SFLT_CFG, adapt_ctl: aec_pkg::RST_ADAPT_CTL,
                       thold: aec_pkg::RST_ERR_THOLD, rdata: 8'h00, st: aec_pkg::ST_WAIT, timer: 16'h0000,
                       err_cnt: 16'h0000, eq: aec_pkg::EQ_START, filt: aec_pkg::FILT_MID, locked: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign reg_rdata_o = s_reg.rdata;
    assign eq_setting_o = s_reg.eq;
    assign sample_filter_o = s_reg.filt;
    assign fixed_test_pattern_lo_o = {8'h00, s_reg.patt_lo};
    assign adapt_locked_o = s_reg.locked;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence wait_done_s;
        s_reg.st == aec_pkg::ST_WAIT && s_reg.timer >= wait_len - 16'h0001;
    endsequence
    sequence errchk_hit_s;
        s_reg.st == aec_pkg::ST_ERRCHK && sel_err;
    endsequence

    ctl_write_a: assert property (reg_wr_i && reg_addr_i == aec_pkg::ADDR_ADAPT_CTL |=>
        err_sel == $past(reg_wdata_i[6:4]))
        else $error("error select not written");
    err_count_a: assert property (s_reg.st == aec_pkg::ST_MONITOR && sel_err && s_reg.err_cnt < 16'h00FF
        && s_reg.timer < half_per - 16'h0001 |=> s_reg.err_cnt == $past(s_reg.err_cnt) + 16'h0001)
        else $error("selected error not counted");
    step_up_a: assert property (s_reg.st == aec_pkg::ST_MONITOR && s_reg.timer >= half_per - 16'h0001
        && s_reg.err_cnt > {8'h00, s_reg.thold} |=> s_reg.st == aec_pkg::ST_WAIT && !adapt_locked_o)
        else $error("threshold crossing did not restart search");
    single_judge_a: assert property (wait_done_s and (!two_step && lock_i) |=>
        s_reg.st == aec_pkg::ST_MONITOR ##1 adapt_locked_o)
        else $error("lock at end of full wait not accepted");
    two_step_a: assert property (wait_done_s and two_step |=> s_reg.st == aec_pkg::ST_ERRCHK)
        else $error("two step wait did not enter error check");
    err_reject_a: assert property (errchk_hit_s |=> s_reg.st == aec_pkg::ST_WAIT && s_reg.timer == 16'h0000)
        else $error("error in second step did not advance");
    loop_order_a: assert property (errchk_hit_s and (filt_en && !loop_order && s_reg.eq != aec_pkg::EQ_MAX
        && $stable(s_reg.sflt_cfg)) |=> eq_setting_o == $past(s_reg.eq) + 4'h1
        && sample_filter_o == $past(s_reg.filt))
        else $error("inner equalizer search wrong");
    filt_off_a: assert property (errchk_hit_s and (!filt_en && $stable(s_reg.sflt_cfg)) |=>
        $stable(sample_filter_o))
        else $error("filter moved while its search is off");
    // a limit write is clamped one edge late, so the write cycle itself is left out
    filt_bound_a: assert property ($stable(s_reg.sflt_cfg) && lower_lim <= upper_lim && upper_lim <= 4'hE
        && !(reg_wr_i && reg_addr_i == aec_pkg::ADDR_SFLT_CFG)
        |=> sample_filter_o >= lower_lim && sample_filter_o <= upper_lim)
        else $error("filter setting outside limits");
    patt_write_a: assert property (reg_wr_i && reg_addr_i == aec_pkg::ADDR_PATT_LO ##1
        reg_addr_i == aec_pkg::ADDR_PATT_LO && !reg_wr_i |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("pattern byte not read back");
    thold_write_a: assert property (reg_wr_i && reg_addr_i == aec_pkg::ADDR_ERR_THOLD |=>
        s_reg.thold == $past(reg_wdata_i))
        else $error("threshold not written");
    sflt_write_a: assert property (reg_wr_i && reg_addr_i == aec_pkg::ADDR_SFLT_CFG |=>
        upper_lim == $past(reg_wdata_i[7:4]) && lower_lim == $past(reg_wdata_i[3:0]))
        else $error("filter limits not written");
endmodule

/* File: include/aec_pkg.sv */
// constants, register map and state type of the adaptive equalizer control slice
// ****************************************************************
// How it works
// - error select bits 6:4, reset all enabled
// - count errors over half relock period
// - errors above threshold step setting upward
// - single step waits full period, checks lock
// - two step: half wait, half error check
// - loop order bit swaps inner and outer search
// - filter search enable, reset one, joins search
// - upper filter limit bits 7:4, reset ten
// - lower filter limit bits 3:0, reset seven
// - limits bound filter setting in every use, unless lower exceeds upper
// - writable low byte of test pattern
// - eight bit error threshold, reset one, zero writable
// ****************************************************************
package aec_pkg;
    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_PATT_LO = 8'h3A;
    localparam logic [7:0] ADDR_RSV_3B = 8'h3B;
    localparam logic [7:0] ADDR_RSV_3C = 8'h3C;
    localparam logic [7:0] ADDR_RSV_3D = 8'h3D;
    localparam logic [7:0] ADDR_RSV_3E = 8'h3E;
    localparam logic [7:0] ADDR_RSV_3F = 8'h3F;
    localparam logic [7:0] ADDR_RSV_40 = 8'h40;
    localparam logic [7:0] ADDR_SFLT_CFG = 8'h41;
    localparam logic [7:0] ADDR_ADAPT_CTL = 8'h42;
    localparam logic [7:0] ADDR_ERR_THOLD = 8'h43;
    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] RST_PATT_LO = 8'h00;
    localparam logic [7:0] RST_RSV_3B = 8'h01;
    localparam logic [7:0] RST_RSV_3C = 8'h14;
    localparam logic [7:0] RST_RSV_3D = 8'h6F;
    localparam logic [7:0] RST_RSV_3E = 8'h00;
    localparam logic [7:0] RST_RSV_3F = 8'h40;
    localparam logic [7:0] RST_RSV_40 = 8'h00;
    localparam logic [7:0] RST_SFLT_CFG = 8'hA7;
    localparam logic [6:0] RST_ADAPT_CTL = 7'h71;
    localparam logic [7:0] RST_ERR_THOLD = 8'h01;
    // ****************************************************************
    // field positions of the control and filter registers
    // ****************************************************************
    localparam int ERR_SEL_HI = 6;
    localparam int ERR_SEL_LO = 4;
    localparam int TWO_STEP_BIT = 2;
    localparam int LOOP_ORDER_BIT = 1;
    localparam int FILT_EN_BIT = 0;
    localparam int UPPER_HI = 7;
    localparam int UPPER_LO = 4;
    localparam int LOWER_HI = 3;
    localparam int LOWER_LO = 0;
    // ****************************************************************
    // setting ranges
    // ****************************************************************
    localparam logic [3:0] EQ_MAX = 4'hF;
    localparam logic [3:0] FILT_MAX = 4'hE;
    localparam logic [3:0] FILT_MID = 4'h7;
    localparam logic [3:0] EQ_START = 4'h0;
    // adaptation states
    typedef enum logic [1:0] {
        ST_WAIT,
        ST_ERRCHK,
        ST_MONITOR
    } aec_state_t;
endpackage

/* File: bench/aec_top_tb.sv */
// self-checking testbench of the adaptive equalizer control slice
`timescale 1ns/1ps
module aec_top_tb;
    // ****************************************************************
    // design ports and bench state
    // ****************************************************************
    logic clock_i; // 10 MHz bench clock
    logic rst_b_i; // async reset, active low
    logic [7:0] reg_addr_i;
    logic reg_wr_i;
    logic [7:0] reg_wdata_i;
    logic [7:0] reg_rdata_o;
    logic [15:0] adapt_relock_period_i;
    logic [2:0] err_drive; // link clock, encoding, parity in control-register bit order
    logic lock_i;
    logic [3:0] eq_setting_o;
    logic [3:0] sample_filter_o;
    logic [15:0] fixed_test_pattern_lo_o;
    logic adapt_locked_o;
    int miscompares = 0; // mismatches seen
    int num_checks = 0; // comparisons made
    int n; // cycles spent waiting
    logic [7:0] rd; // last read value
    // reset table: address, expected value
    logic [15:0] rst_rows [11] = '{16'h3A00, 16'h3B01, 16'h3C14, 16'h3D6F, 16'h3E00, 16'h3F40,
        16'h4000, 16'h41A7, 16'h4271, 16'h4301, 16'h4400};
    // register rows: address, write data, expected read back
    logic [23:0] reg_rows [7] = '{24'h3A5555, 24'h3AAAAA, 24'h42FF7F, 24'h41A9A9, 24'h43FFFF,
        24'h50AA00, 24'h3B5A5A};
    // search rows: control, limits, eq and filter after first and after second step
    logic [31:0] step_rows [4] = '{32'h71A7_1727, 32'h73A7_0809, 32'h72A7_1727, 32'h7398_0918};
    // ****************************************************************
    // clock, design and watchdog
    // ****************************************************************
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    aec_top dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .adapt_relock_period_i(adapt_relock_period_i),
        .link_clock_err_i(err_drive[2]), .encoding_err_i(err_drive[1]), .parity_err_i(err_drive[0]),
        .lock_i(lock_i), .eq_setting_o(eq_setting_o), .sample_filter_o(sample_filter_o),
        .fixed_test_pattern_lo_o(fixed_test_pattern_lo_o), .adapt_locked_o(adapt_locked_o));
    // a hang anywhere ends the run well after the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        complete_run();
    end
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // reset held one cycle; outputs are checked while it is held
    task automatic do_reset(input logic [15:0] period, input logic lock);
        @(posedge clock_i);
        rst_b_i <= 1'b0;
        adapt_relock_period_i <= period;
        lock_i <= lock;
        err_drive <= 3'h0;
        @(negedge clock_i);
        check({reg_rdata_o, eq_setting_o, sample_filter_o}, 16'h0007);
        check({fixed_test_pattern_lo_o[7:0], 7'h00, adapt_locked_o}, 16'h0000);
        @(posedge clock_i);
        rst_b_i <= 1'b1;
    endtask
    // one write strobe, taken at the second edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wr_i <= 1'b1;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    // read data is registered: it shows one edge after the address
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        @(posedge clock_i);
        @(negedge clock_i);
        d = reg_rdata_o;
    endtask
    // waits for the next change of the search settings, bounded
    task automatic wait_step(input int bound, output int cnt);
        logic [7:0] was;
        was = {eq_setting_o, sample_filter_o};
        cnt = 0;
        while ({eq_setting_o, sample_filter_o} === was && cnt < bound) begin
            @(negedge clock_i);
            cnt++;
        end
        check(16'(cnt < bound), 16'h0001);
    endtask
    task automatic wait_locked();
        n = 0;
        while (adapt_locked_o !== 1'b1 && n < 100) begin
            @(negedge clock_i);
            n++;
        end
        check(16'(adapt_locked_o), 16'h0001);
    endtask
    // eight error cycles: one window boundary can split them, but one part always keeps four or more
    task automatic pulse_err(input logic [2:0] m);
        @(posedge clock_i);
        err_drive <= m;
        repeat (8) @(posedge clock_i);
        err_drive <= 3'h0;
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst_b_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_wdata_i = 8'h00;
        adapt_relock_period_i = 16'h0028;
        err_drive = 3'h0;
        lock_i = 1'b0;
        do_reset(16'h0028, 1'b0);
        // reset values of every mapped place and one unmapped one
        foreach (rst_rows[i]) begin
            rd_reg(rst_rows[i][15:8], rd);
            check(16'(rd), 16'(rst_rows[i][7:0]));
        end
        $display("test reset values done");
        // ordinary write and read-back rows, read-only bit and unmapped place included
        foreach (reg_rows[i]) begin
            wr_reg(reg_rows[i][23:16], reg_rows[i][15:8]);
            rd_reg(reg_rows[i][23:16], rd);
            check(16'(rd), 16'(reg_rows[i][7:0]));
        end
        check(fixed_test_pattern_lo_o, 16'h00AA);
        $display("test register rows done");
        // search order rows: no lock, so every relock period ends in a step
        foreach (step_rows[i]) begin
            do_reset(16'h0028, 1'b0);
            wr_reg(8'h41, step_rows[i][23:16]);
            wr_reg(8'h42, step_rows[i][31:24]);
            @(negedge clock_i);
            check(16'(sample_filter_o >= step_rows[i][19:16] && sample_filter_o <= step_rows[i][23:20]), 1);
            wait_step(100, n);
            check({eq_setting_o, sample_filter_o}, 16'(step_rows[i][15:8]));
            wait_step(100, n);
            check({eq_setting_o, sample_filter_o}, 16'(step_rows[i][7:0]));
            check(16'(n >= 38 && n <= 42), 16'h0001);
        end
        $display("test search order done");
        // two-step: errors during the check half step at once, one cycle after the half-period wait
        do_reset(16'h0028, 1'b0);
        wr_reg(8'h42, 8'h75);
        wait_step(100, n);
        @(posedge clock_i);
        err_drive <= 3'h1;
        wait_step(100, n);
        check(16'(n >= 19 && n <= 25), 16'h0001);
        // filter search off with filter inner: the next rejection moves only the equalizer
        wr_reg(8'h42, 8'h76);
        wait_step(100, n);
        @(posedge clock_i);
        err_drive <= 3'h0;
        check({eq_setting_o, sample_filter_o}, 16'h0037);
        check(16'(adapt_locked_o), 16'h0000);
        $display("test two step done");
        // lock at the end of the full period, then each error class forces a step
        do_reset(16'h0028, 1'b1);
        wait_locked();
        check(16'(n >= 39 && n <= 43), 16'h0001);
        check(16'(eq_setting_o), 16'h0000);
        for (int k = 0; k < 3; k++) begin
            pulse_err(3'(4 >> k));
            wait_step(60, n);
            check({eq_setting_o, 3'h0, adapt_locked_o}, 8'((k + 1) << 4));
            wait_locked();
        end
        // only parity selected: link clock errors are ignored
        wr_reg(8'h42, 8'h11);
        pulse_err(3'h4);
        repeat (50) @(negedge clock_i);
        check({eq_setting_o, 3'h0, adapt_locked_o}, 8'h31);
        // eight errors against a threshold of eight do not exceed it
        wr_reg(8'h43, 8'h08);
        pulse_err(3'h1);
        repeat (50) @(negedge clock_i);
        check({eq_setting_o, 3'h0, adapt_locked_o}, 8'h31);
        $display("test error monitor done");
        complete_run();
    end
endmodule
